// ==== design/wdr_pkg.sv ====
// Package for the watchdog and reset-cause block: register map, field
// positions, reset values, timing counts and carrier types.
// Assumes a 50 MHz ref_clk and a 32-bit APB register bus.
package wdr_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] WDR_OFS_CAUSE = 8'h00;
  localparam logic [7:0] WDR_OFS_WDCTL = 8'h04;

  // reset_cause_status field positions
  localparam int WDR_BIT_PWRUP = 0;
  localparam int WDR_BIT_PIN = 1;
  localparam int WDR_BIT_DROP = 2;
  localparam int WDR_BIT_DOG = 3;
  localparam int WDR_BIT_TPORT = 4;

  // watchdog_control field positions
  localparam int WDR_BIT_PSC_LO = 0;
  localparam int WDR_BIT_EN = 3;
  localparam int WDR_BIT_CE = 4;

  // Values after power-on reset
  localparam logic [4:0] WDR_CAUSE_RST = 5'h01;
  localparam logic [2:0] WDR_PSC_RST = 3'h0;

  // Brown-out level code that switches detection off
  localparam logic [2:0] WDR_BOD_OFF = 3'h7;

  // Clock and watchdog oscillator rates
  localparam int WDR_CLK_HZ = 50_000_000;
  localparam int WDR_DOG_OSC_HZ = 1_000_000;
  localparam int WDR_DOG_DIV = WDR_CLK_HZ / WDR_DOG_OSC_HZ;

  // Change-enable window in clock cycles
  localparam logic [2:0] WDR_CE_CYCLES = 3'h4;

  // Shortest time-out is 16K oscillator cycles, i.e. 2 to the 14th
  localparam int WDR_TO_BASE_LOG2 = 14;
  localparam int WDR_CNT_W = 21;

  // Start-up delay after all reset sources end
  localparam int WDR_STARTUP_US = 65;
  localparam int WDR_STARTUP_CYC = WDR_STARTUP_US * (WDR_CLK_HZ / 1_000_000);

  // Watchdog control fields
  typedef struct packed {
    logic ce;
    logic en;
    logic [2:0] psc;
  } wdr_wdctl_t;

  // Live reset sources
  typedef struct packed {
    logic tport;
    logic dog;
    logic drop;
    logic pin;
  } wdr_src_t;

  // Reset sequencer states, Gray along RUN -> HOLD -> DELAY -> HOLD but not DELAY -> RUN
  typedef enum logic [1:0] {
    WDR_RUN = 2'b00,
    WDR_HOLD = 2'b01,
    WDR_DELAY = 2'b11
  } wdr_seq_t;

endpackage

// ==== design/wdr_top.sv ====
// Watchdog timer with timed-sequence control register, reset-cause flags,
// reset stretching and the digital enables of brown-out and bandgap.
// Assumes inputs synchronous to ref_clk; rst is the power-on reset.
`timescale 1ns/1ps
module wdr_top
  import wdr_pkg::*;
#(
  parameter int STARTUP_CYC = WDR_STARTUP_CYC,
  // Clocks per watchdog oscillator tick, at most 64; a bench may shorten it
  parameter int DOG_DIV = WDR_DOG_DIV
)
(
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fuses and live conditions
  input wire logic [2:0] brownout_level_fuse,
  input wire logic dog_always_on_fuse,
  input wire logic supply_low,
  input wire logic pin_reset_n,
  input wire logic testport_reset_reg,
  input wire logic dog_restart_instr,
  input wire logic comparator_bandgap_select,
  input wire logic converter_enable,
  // Reset and reference outputs
  output logic dog_reset_pulse,
  output logic brownout_reset,
  output logic core_reset,
  output logic bandgap_enable
);

  // Time-out length for a prescale code, as a terminal count
  function automatic logic [WDR_CNT_W-1:0] dog_limit(input logic [2:0] psc);
    logic [WDR_CNT_W:0] one_hot;
    one_hot = (WDR_CNT_W+1)'(1) << (WDR_TO_BASE_LOG2 + int'(psc));
    dog_limit = WDR_CNT_W'(one_hot - (WDR_CNT_W+1)'(1));
  endfunction

  wdr_wdctl_t ctl_r;
  logic [2:0] ce_cnt_r;
  logic [4:0] cause_r;
  logic [5:0] div_r;
  logic osc_tick;
  logic [WDR_CNT_W-1:0] dog_cnt_r;
  logic dog_pulse_r;
  logic drop_r;
  logic core_reset_r;
  wdr_seq_t seq_r;
  wdr_seq_t seq_nxt;
  logic [12:0] delay_r;
  logic [31:0] prdata_r;
  wdr_src_t src;
  logic bod_on;
  logic dog_on;
  logic setup_ph;
  logic wr_acc;
  logic hit_cause;
  logic hit_ctl;
  logic [4:0] cause_set;

  // Brown-out detection enable from the level fuse
  assign bod_on = (brownout_level_fuse != WDR_BOD_OFF);

  // Effective enable: level 2 forces it on
  assign dog_on = dog_always_on_fuse | ctl_r.en;

  // Bandgap reference request
  assign bandgap_enable = bod_on | comparator_bandgap_select | converter_enable;

  // Live reset sources other than power-on
  assign src.pin = ~pin_reset_n;
  assign src.drop = drop_r;
  assign src.dog = dog_pulse_r;
  assign src.tport = testport_reset_reg;

  // APB decode
  assign hit_cause = (paddr == WDR_OFS_CAUSE);
  assign hit_ctl = (paddr == WDR_OFS_WDCTL);
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_cause | hit_ctl);
  assign prdata = prdata_r;

  // Read data captured in the setup cycle, valid through the access cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (setup_ph & ~pwrite)
    begin
      if (hit_cause)
      begin
        prdata_r <= {27'h0000000, cause_r};
      end
      else if (hit_ctl)
      begin
        prdata_r <= {27'h0000000, ctl_r.ce, dog_on, ctl_r.psc};
      end
      else
      begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // Brown-out reset asserts one clock after the supply-low indication is seen
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      drop_r <= 1'b0;
    end
    else
    begin
      drop_r <= bod_on & supply_low;
    end
  end
  assign brownout_reset = drop_r;

  // Flags set by each reset source; set wins over a software clear
  always_comb
  begin
    cause_set = 5'h00;
    cause_set[WDR_BIT_TPORT] = src.tport;
    cause_set[WDR_BIT_DOG] = src.dog;
    cause_set[WDR_BIT_DROP] = src.drop;
    cause_set[WDR_BIT_PIN] = src.pin;
  end

  // Reset-cause status: power-on loads only the power-up flag
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cause_r <= WDR_CAUSE_RST;
    end
    else if (wr_acc & hit_cause)
    begin
      cause_r <= (cause_r & pwdata[4:0]) | cause_set;
    end
    else
    begin
      cause_r <= cause_r | cause_set;
    end
  end

  // Watchdog control with timed change sequence
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_r <= '{ce: 1'b0, en: 1'b0, psc: WDR_PSC_RST};
      ce_cnt_r <= 3'h0;
    end
    else if (core_reset_r)
    begin
      ctl_r <= '{ce: 1'b0, en: 1'b0, psc: WDR_PSC_RST};
      ce_cnt_r <= 3'h0;
    end
    else if (wr_acc & hit_ctl)
    begin
      if (pwdata[WDR_BIT_EN])
      begin
        ctl_r.en <= 1'b1;
      end
      else if (ctl_r.ce)
      begin
        ctl_r.en <= 1'b0;
      end
      if (ctl_r.ce)
      begin
        ctl_r.psc <= pwdata[WDR_BIT_PSC_LO +: 3];
      end
      if (pwdata[WDR_BIT_CE])
      begin
        ctl_r.ce <= 1'b1;
        ce_cnt_r <= WDR_CE_CYCLES;
      end
      else if (ce_cnt_r == 3'h1)
      begin
        ctl_r.ce <= 1'b0;
        ce_cnt_r <= 3'h0;
      end
      else if (ce_cnt_r != 3'h0)
      begin
        ce_cnt_r <= ce_cnt_r - 3'h1;
      end
    end
    else if (ce_cnt_r != 3'h0)
    begin
      ce_cnt_r <= ce_cnt_r - 3'h1;
      if (ce_cnt_r == 3'h1)
      begin
        ctl_r.ce <= 1'b0;
      end
    end
  end

  // Divider giving one tick per watchdog oscillator period
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_r <= 6'h00;
    end
    else if (div_r == 6'(DOG_DIV - 1))
    begin
      div_r <= 6'h00;
    end
    else
    begin
      div_r <= div_r + 6'h01;
    end
  end
  assign osc_tick = (div_r == 6'(DOG_DIV - 1));

  // Watchdog counter and expiry pulse
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dog_cnt_r <= '0;
      dog_pulse_r <= 1'b0;
    end
    else
    begin
      dog_pulse_r <= 1'b0;
      if (core_reset_r | ~dog_on | dog_pulse_r)
      begin
        dog_cnt_r <= '0;
      end
      else if (dog_restart_instr)
      begin
        dog_cnt_r <= '0;
      end
      else if (osc_tick)
      begin
        if (dog_cnt_r == dog_limit(ctl_r.psc))
        begin
          dog_cnt_r <= '0;
          dog_pulse_r <= 1'b1;
        end
        else
        begin
          dog_cnt_r <= dog_cnt_r + WDR_CNT_W'(1);
        end
      end
    end
  end
  assign dog_reset_pulse = dog_pulse_r;

  // Reset sequencer: hold while any source is live, then stretch
  always_comb
  begin
    seq_nxt = seq_r;
    unique case (seq_r)
      WDR_RUN:
      begin
        if (|src)
        begin
          seq_nxt = WDR_HOLD;
        end
      end
      WDR_HOLD:
      begin
        if (~|src)
        begin
          seq_nxt = WDR_DELAY;
        end
      end
      WDR_DELAY:
      begin
        if (|src)
        begin
          seq_nxt = WDR_HOLD;
        end
        else if (delay_r == 13'h0001)
        begin
          seq_nxt = WDR_RUN;
        end
      end
      default:
      begin
        seq_nxt = WDR_HOLD;
      end
    endcase
  end

  // Sequencer state and start-up delay count; power-on starts in the delay
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      seq_r <= WDR_DELAY;
      delay_r <= 13'(STARTUP_CYC);
      core_reset_r <= 1'b1;
    end
    else
    begin
      seq_r <= seq_nxt;
      core_reset_r <= (seq_nxt != WDR_RUN);
      if (seq_nxt != WDR_DELAY)
      begin
        delay_r <= 13'(STARTUP_CYC);
      end
      else if (seq_r == WDR_DELAY)
      begin
        delay_r <= delay_r - 13'h0001;
      end
    end
  end
  assign core_reset = core_reset_r;

endmodule

// ==== bench/wdr_top_sva.sv ====
// Concurrent checks on the watchdog and reset-cause block ports.
// Assumes it is bound into wdr_top and sees only that module's ports.
`timescale 1ns/1ps
module wdr_top_chk
  import wdr_pkg::*;
#(
  parameter int STARTUP_CYC = 20
)
(
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fuses and live conditions
  input wire logic [2:0] brownout_level_fuse,
  input wire logic supply_low,
  input wire logic pin_reset_n,
  input wire logic testport_reset_reg,
  input wire logic comparator_bandgap_select,
  input wire logic converter_enable,
  // Reset and reference outputs
  input wire logic dog_reset_pulse,
  input wire logic brownout_reset,
  input wire logic core_reset,
  input wire logic bandgap_enable
);
  // All checks run on ref_clk and pause during power-on reset
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Watchdog expiry pulse and the hold it causes
  dog_pulse_one_a: assert property (dog_reset_pulse |=> !dog_reset_pulse)
    else $error("watchdog reset pulse longer than one cycle");
  dog_hold_a: assert property (dog_reset_pulse |=> core_reset)
    else $error("core not held after watchdog pulse");
  dog_quiet_a: assert property (core_reset |=> !dog_reset_pulse)
    else $error("watchdog pulse while counter should be cleared");
  // Brown-out detection and restart delay
  bod_fire_a: assert property ((brownout_level_fuse != WDR_BOD_OFF && supply_low) |=> brownout_reset)
    else $error("brown-out reset missing");
  bod_off_a: assert property ((brownout_level_fuse == WDR_BOD_OFF) |=> !brownout_reset)
    else $error("brown-out reset with detection off");
  bod_core_a: assert property (brownout_reset |=> core_reset)
    else $error("core not held during brown-out");
  bod_startup_a: assert property ($fell(brownout_reset) |-> core_reset [*8])
    else $error("core released before start-up delay");
  // Other live sources hold the core
  pin_hold_a: assert property (!pin_reset_n |=> core_reset)
    else $error("core not held during pin reset");
  tport_hold_a: assert property (testport_reset_reg |=> core_reset)
    else $error("core not held during test-port reset");
  // Reference enable is a plain OR
  bandgap_or_a: assert property (bandgap_enable == (brownout_level_fuse != WDR_BOD_OFF || comparator_bandgap_select || converter_enable))
    else $error("bandgap enable wrong");

  // Main scenarios reached
  cover property (brownout_reset);
  cover property (!pin_reset_n ##1 core_reset);
  cover property ($fell(core_reset));
  cover property (dog_reset_pulse ##1 core_reset);
endmodule

bind wdr_top wdr_top_chk #(.STARTUP_CYC(STARTUP_CYC)) wdr_top_chk_i (.ref_clk, .rst, .brownout_level_fuse,
  .supply_low, .pin_reset_n, .testport_reset_reg, .comparator_bandgap_select, .converter_enable,
  .dog_reset_pulse, .brownout_reset, .core_reset, .bandgap_enable);

// ==== bench/testbench.sv ====
// Self-checking bench for the watchdog and reset-cause block.
// Assumes wdr_top with a short start-up delay, a watchdog tick every clock and zero-wait APB.
`timescale 1ns/1ps
module testbench;
  import wdr_pkg::*;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] brownout_level_fuse = 3'h0;
  logic dog_always_on_fuse = 1'b0;
  logic supply_low = 1'b0;
  logic pin_reset_n = 1'b1;
  logic testport_reset_reg = 1'b0;
  logic dog_restart_instr = 1'b0;
  logic comparator_bandgap_select = 1'b0;
  logic converter_enable = 1'b0;
  logic dog_reset_pulse;
  logic brownout_reset;
  logic core_reset;
  logic bandgap_enable;
  logic [31:0] q;
  logic err;
  int miscompares = 0;
  int tests_run = 0;

  wdr_top #(.STARTUP_CYC(20), .DOG_DIV(1)) wdr_top_i (.ref_clk, .rst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata,
    .pready, .pslverr, .brownout_level_fuse, .dog_always_on_fuse, .supply_low, .pin_reset_n, .testport_reset_reg,
    .dog_restart_instr, .comparator_bandgap_select, .converter_enable, .dog_reset_pulse, .brownout_reset,
    .core_reset, .bandgap_enable);

  // 50 MHz clock
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask

  // Wait, bounded, for the core to leave reset
  task automatic boot;
    repeat (100) if (core_reset === 1'b1) @(posedge ref_clk);
    chk(core_reset, 1'b0);
  endtask

  task automatic t_regs;
    boot();
    rd(WDR_OFS_CAUSE, 32'h01);
    rd(WDR_OFS_WDCTL, 32'h00);
    apb(WDR_OFS_CAUSE, 1'b1, 32'h0);
    rd(WDR_OFS_CAUSE, 32'h00);
    rd(8'h08, 32'h0);
    chk(err, 1'b1);
    $display("test regs done");
  endtask

  // Pin, brown-out and test-port sources in turn
  task automatic t_src;
    for (int i = 0; i < 3; i++)
    begin
      pin_reset_n <= (i != 0);
      supply_low <= (i == 1);
      testport_reset_reg <= (i == 2);
      repeat (3) @(posedge ref_clk);
      chk(core_reset, 1'b1);
      chk(brownout_reset, i == 1);
      pin_reset_n <= 1'b1;
      supply_low <= 1'b0;
      testport_reset_reg <= 1'b0;
      boot();
      rd(WDR_OFS_CAUSE, 32'h1 << (i == 0 ? 1 : (i == 1 ? 2 : 4)));
      apb(WDR_OFS_CAUSE, 1'b1, 32'h0);
    end
    $display("test src done");
  endtask

  // Timed sequence at level 1
  task automatic t_ctl;
    apb(WDR_OFS_WDCTL, 1'b1, 32'hE8);
    rd(WDR_OFS_WDCTL, 32'h08);
    apb(WDR_OFS_WDCTL, 1'b1, 32'h05);
    rd(WDR_OFS_WDCTL, 32'h08);
    apb(WDR_OFS_WDCTL, 1'b1, 32'h18);
    apb(WDR_OFS_WDCTL, 1'b1, 32'h05);
    rd(WDR_OFS_WDCTL, 32'h05);
    apb(WDR_OFS_WDCTL, 1'b1, 32'h18);
    repeat (6) @(posedge ref_clk);
    apb(WDR_OFS_WDCTL, 1'b1, 32'h00);
    rd(WDR_OFS_WDCTL, 32'h0D);
    $display("test ctl done");
  endtask

  // Level 2, chip reset and a second power-on reset
  task automatic t_lvl2;
    dog_always_on_fuse <= 1'b1;
    apb(WDR_OFS_WDCTL, 1'b1, 32'h18);
    apb(WDR_OFS_WDCTL, 1'b1, 32'h03);
    rd(WDR_OFS_WDCTL, 32'h0B);
    dog_always_on_fuse <= 1'b0;
    pin_reset_n <= 1'b0;
    @(posedge ref_clk);
    pin_reset_n <= 1'b1;
    boot();
    rd(WDR_OFS_WDCTL, 32'h00);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    boot();
    rd(WDR_OFS_CAUSE, 32'h01);
    $display("test lvl2 done");
  endtask

  // Reference enable and brown-out off code
  task automatic t_bg;
    for (int i = 0; i < 8; i++)
    begin
      brownout_level_fuse <= i[0] ? WDR_BOD_OFF : 3'h0;
      comparator_bandgap_select <= i[1];
      converter_enable <= i[2];
      supply_low <= i[0];
      repeat (3) @(posedge ref_clk);
      chk(bandgap_enable, !i[0] || i[1] || i[2]);
      chk(brownout_reset, 1'b0);
    end
    supply_low <= 1'b0;
    $display("test bg done");
  endtask

  // Restart, expiry after 16K ticks, one-cycle pulse, flag and stretched reset
  task automatic t_dog;
    int n;
    apb(WDR_OFS_WDCTL, 1'b1, 32'h08);
    repeat (10000) @(posedge ref_clk);
    dog_restart_instr <= 1'b1;
    @(posedge ref_clk);
    dog_restart_instr <= 1'b0;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (dog_reset_pulse !== 1'b1 && n < 20000);
    chk(n, 32'h0000_4001);
    @(negedge ref_clk);
    chk(dog_reset_pulse, 1'b0);
    chk(core_reset, 1'b1);
    boot();
    rd(WDR_OFS_CAUSE, 32'h09);
    rd(WDR_OFS_WDCTL, 32'h00);
    $display("test dog done");
  endtask

  task automatic test_done;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_src();
    t_ctl();
    t_lvl2();
    t_bg();
    t_dog();
    test_done();
  end

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
endmodule
